// ### verilog/vbi_slice_pkg.sv
// Purpose: Shared constants and types for the blanking-line slice mode registers.
// Assumes: 32-bit AXI4-Lite data, one register per aligned word.
// Notes:   Register indices are word indices; byte address is four times the index.
package vbi_slice_pkg;

	// ============================================================
	// Bus geometry
	localparam int          ADDR_W        = 16;
	localparam int          DATA_W        = 32;
	localparam int          IDX_W         = 14;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// ============================================================
	// Register indices
	localparam int          LINE_COUNT    = 8;
	localparam int          CUSTOM_COUNT  = 3;
	localparam logic [IDX_W-1:0] LINE1_IDX    = 14'h0424;
	localparam logic [IDX_W-1:0] LINE2_IDX    = 14'h0425;
	localparam logic [IDX_W-1:0] LINE3_IDX    = 14'h0426;
	localparam logic [IDX_W-1:0] LINE4_IDX    = 14'h0427;
	localparam logic [IDX_W-1:0] LINE5_IDX    = 14'h0428;
	localparam logic [IDX_W-1:0] LINE6_IDX    = 14'h0429;
	localparam logic [IDX_W-1:0] LINE7_IDX    = 14'h042A;
	localparam logic [IDX_W-1:0] LINE8_IDX    = 14'h042B;
	localparam logic [IDX_W-1:0] CUSTOM1_IDX  = 14'h04F0;
	localparam logic [IDX_W-1:0] CUSTOM2_IDX  = 14'h04F1;
	localparam logic [IDX_W-1:0] CUSTOM3_IDX  = 14'h04F2;
	localparam logic [IDX_W-1:0] STD_CTRL_IDX = 14'h04F8;
	localparam logic [IDX_W-1:0] STATUS_IDX   = 14'h04F9;

	// ============================================================
	// Line mode fields
	localparam int          ODD_LSB       = 4;
	localparam int          EVEN_LSB      = 0;
	localparam int          CODE_W        = 4;
	localparam logic [7:0]  LINE_RESET    = 8'h00;

	// ============================================================
	// Mode codes as written by software
	localparam logic [3:0]  CODE_NONE     = 4'h0;
	localparam logic [3:0]  CODE_TT_1     = 4'h1;
	localparam logic [3:0]  CODE_TT_2     = 4'h2;
	localparam logic [3:0]  CODE_TT_3     = 4'h3;
	localparam logic [3:0]  CODE_WSS      = 4'h4;
	localparam logic [3:0]  CODE_VITC     = 4'h5;
	localparam logic [3:0]  CODE_CC       = 4'h6;
	localparam logic [3:0]  CODE_7        = 4'h7;
	localparam logic [3:0]  CODE_8        = 4'h8;
	localparam logic [3:0]  CODE_CUSTOM1  = 4'h9;
	localparam logic [3:0]  CODE_CUSTOM2  = 4'hA;
	localparam logic [3:0]  CODE_CUSTOM3  = 4'hB;

	// ============================================================
	// Resolved slice formats
	typedef enum logic [3:0] {
		FMT_NONE,
		FMT_TT_A,
		FMT_TT_B,
		FMT_TT_C,
		FMT_TT_D,
		FMT_WSS,
		FMT_VITC,
		FMT_CC,
		FMT_VPS,
		FMT_PROP_1X,
		FMT_PROP_2X
	} slice_fmt_e;

	// ============================================================
	// Custom setup fields: [3:0] format, [4] 625-line standard
	localparam int          CUST_FMT_LSB  = 0;
	localparam int          CUST_STD_BIT  = 4;
	localparam logic [7:0]  CUSTOM1_RESET = {3'h0, 1'b0, 4'(FMT_CC)};
	localparam logic [7:0]  CUSTOM2_RESET = {3'h0, 1'b1, 4'(FMT_WSS)};
	localparam logic [7:0]  CUSTOM3_RESET = {3'h0, 1'b0, 4'(FMT_TT_C)};

	// ============================================================
	// Standard control: [0] 625-line input
	localparam int          STD625_BIT    = 0;
	localparam logic [7:0]  STD_RESET     = 8'h00;

endpackage

// ### verilog/cfg_byte_reg.sv
// Purpose: One software-written byte register with a per-instance reset value.
// Assumes: Write strobe already decoded for this register.
// Notes:   Synchronous active-low reset.
`timescale 1ns/1ps
module cfg_byte_reg #(
	parameter logic [7:0] RESET_VAL = 8'h00
) (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_data,
	output logic      [7:0] value
);

	logic [7:0] value_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			value_ff <= RESET_VAL;
		end else if (wr_en) begin
			value_ff <= wr_data;
		end
	end

	assign value = value_ff;

endmodule // cfg_byte_reg

// ### verilog/slice_mode_decode.sv
// Purpose: Map a 4-bit line mode code to a slice format for the active standard.
// Assumes: Custom codes are resolved by the caller from the custom setups.
// Notes:   Purely combinational.
`timescale 1ns/1ps
module slice_mode_decode
	import vbi_slice_pkg::*;
(
	input  wire logic             [3:0] code,
	input  wire logic                   std625,
	output vbi_slice_pkg::slice_fmt_e   fmt,
	output logic                        is_custom,
	output logic                  [1:0] custom_sel
);

	always_comb begin
		fmt        = FMT_NONE;
		is_custom  = 1'b0;
		custom_sel = 2'h0;
		unique case (code)
			CODE_TT_1: fmt = std625 ? FMT_TT_B : FMT_TT_D;
			CODE_TT_2: fmt = std625 ? FMT_TT_A : FMT_TT_C;
			CODE_TT_3: fmt = std625 ? FMT_NONE : FMT_TT_D;
			CODE_WSS:  fmt = FMT_WSS;
			CODE_VITC: fmt = FMT_VITC;
			CODE_CC:   fmt = FMT_CC;
			CODE_7:    fmt = std625 ? FMT_VPS : FMT_PROP_1X;
			CODE_8:    fmt = std625 ? FMT_NONE : FMT_PROP_2X;
			CODE_CUSTOM1: begin
				is_custom  = 1'b1;
				custom_sel = 2'h0;
			end
			CODE_CUSTOM2: begin
				is_custom  = 1'b1;
				custom_sel = 2'h1;
			end
			CODE_CUSTOM3: begin
				is_custom  = 1'b1;
				custom_sel = 2'h2;
			end
			default:   fmt = FMT_NONE;
		endcase
	end

endmodule // slice_mode_decode

// ### verilog/vbi_line_slice_mode_regs.sv
// Purpose: Per-line blanking slice mode registers with AXI4-Lite access and
//          resolution of the format to slice on the current line and field.
// Assumes: Line pointer and field flag come from the decoder timing, on aclk.
// Notes:   One clock, synchronous reset, rules below.
// Notes on behaviour
// - Three custom formats, each with its own setup register, are chosen by codes 1001, 1010 and 1011.
// - After reset the custom setups hold 525 closed caption, 625 widescreen signalling and 525 teletext C.
// - Eight byte registers each steer one blanking line, the first at the offset line, then successive lines.
// - Bits 7 to 4 give the odd-field code and bits 3 to 0 the even-field code.
// - On 525-line input the codes decode to none, teletext D, C, D, WSS, VITC, CC, proprietary 1x/2x, custom.
// - On 625-line input the codes decode to teletext B, A, WSS, VITC, CC, VPS and custom, 0011 and 1000 reserved.
// - Lines two to eight take the same code set at consecutive addresses.
// - Every line register resets to zero so nothing is sliced until programmed.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
module vbi_line_slice_mode_regs
	import vbi_slice_pkg::*;
#(
	parameter int LINES = 8
) (
	input  wire logic                         aclk,
	input  wire logic                         aresetn,
	// AXI4-Lite slave
	input  wire logic [vbi_slice_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                         s_axi_awvalid,
	output logic                              s_axi_awready,
	input  wire logic [vbi_slice_pkg::DATA_W-1:0] s_axi_wdata,
	input  wire logic                   [3:0] s_axi_wstrb,
	input  wire logic                         s_axi_wvalid,
	output logic                              s_axi_wready,
	output logic                        [1:0] s_axi_bresp,
	output logic                              s_axi_bvalid,
	input  wire logic                         s_axi_bready,
	input  wire logic [vbi_slice_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                         s_axi_arvalid,
	output logic                              s_axi_arready,
	output logic [vbi_slice_pkg::DATA_W-1:0]  s_axi_rdata,
	output logic                        [1:0] s_axi_rresp,
	output logic                              s_axi_rvalid,
	input  wire logic                         s_axi_rready,
	// Slicer timing
	input  wire logic                   [2:0] line_sel,
	input  wire logic                         field_odd,
	input  wire logic                         line_active,
	// Resolved format for the slicer
	output vbi_slice_pkg::slice_fmt_e         slice_format,
	output logic                              slice_enable,
	output logic                              slice_custom,
	output logic                        [1:0] slice_custom_sel,
	output logic                              slice_std625
);

	import vbi_slice_pkg::*;

	// ============================================================
	// Write channel capture
	logic                 aw_held_ff;
	logic                 w_held_ff;
	logic [IDX_W-1:0]     aw_idx_ff;
	logic [7:0]           w_byte_ff;
	logic                 w_lane0_ff;
	logic                 bvalid_ff;
	logic [1:0]           bresp_ff;
	logic                 wr_go;
	logic                 wr_hit;

	// Address and data are taken in either order, one write at a time
	assign s_axi_awready = !aw_held_ff && !bvalid_ff;
	assign s_axi_wready  = !w_held_ff && !bvalid_ff;
	// Store fires one edge after the later half arrives
	assign wr_go         = aw_held_ff && w_held_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			aw_idx_ff  <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_ff <= 1'b1;
			aw_idx_ff  <= s_axi_awaddr[ADDR_W-1:2];
		end else if (wr_go) begin
			aw_held_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_ff  <= 1'b0;
			w_byte_ff  <= 8'h00;
			w_lane0_ff <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_ff  <= 1'b1;
			w_byte_ff  <= s_axi_wdata[7:0];
			w_lane0_ff <= s_axi_wstrb[0];
		end else if (wr_go) begin
			w_held_ff  <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// Response stands until bready so a slow master loses nothing
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp  = bresp_ff;

	// ============================================================
	// Address decode for writes
	logic [LINES-1:0]        line_wr;
	logic [CUSTOM_COUNT-1:0] cust_wr;
	logic                    std_wr;

	always_comb begin
		// Only byte lane 0 holds a register; upper lanes are ignored
		line_wr = '0;
		cust_wr = '0;
		std_wr  = 1'b0;
		wr_hit  = 1'b0;
		for (int i = 0; i < LINES; i++) begin
			if (aw_idx_ff == LINE1_IDX + IDX_W'(i)) begin
				line_wr[i] = wr_go && w_lane0_ff;
				wr_hit     = 1'b1;
			end
		end
		for (int k = 0; k < CUSTOM_COUNT; k++) begin
			if (aw_idx_ff == CUSTOM1_IDX + IDX_W'(k)) begin
				cust_wr[k] = wr_go && w_lane0_ff;
				wr_hit     = 1'b1;
			end
		end
		if (aw_idx_ff == STD_CTRL_IDX) begin
			std_wr = wr_go && w_lane0_ff;
			wr_hit = 1'b1;
		end
		// Status is read-only; a write is accepted and dropped
		if (aw_idx_ff == STATUS_IDX) begin
			wr_hit = 1'b1;
		end
	end

	// ============================================================
	// Register storage
	logic [7:0] line_mode [LINES];
	logic [7:0] cust_setup [CUSTOM_COUNT];
	logic [7:0] std_ctrl;

	// Custom setups wake up as the three built-in formats
	localparam logic [7:0] CUST_RESETS [CUSTOM_COUNT] = '{CUSTOM1_RESET, CUSTOM2_RESET, CUSTOM3_RESET};

	// One register module per line keeps the reset value per instance
	genvar g;
	generate
		for (g = 0; g < LINES; g++) begin : g_line
			cfg_byte_reg #(
				.RESET_VAL (LINE_RESET)
			) u_line (
				.aclk    (aclk),
				.aresetn (aresetn),
				.wr_en   (line_wr[g]),
				.wr_data (w_byte_ff),
				.value   (line_mode[g])
			);
		end
		for (g = 0; g < CUSTOM_COUNT; g++) begin : g_cust
			cfg_byte_reg #(
				.RESET_VAL (CUST_RESETS[g])
			) u_cust (
				.aclk    (aclk),
				.aresetn (aresetn),
				.wr_en   (cust_wr[g]),
				.wr_data (w_byte_ff),
				.value   (cust_setup[g])
			);
		end
	endgenerate

	cfg_byte_reg #(
		.RESET_VAL (STD_RESET)
	) u_std (
		.aclk    (aclk),
		.aresetn (aresetn),
		.wr_en   (std_wr),
		.wr_data (w_byte_ff),
		.value   (std_ctrl)
	);

	// ============================================================
	// Line and field resolution
	logic        std625;
	logic [7:0]  cur_line;
	logic [3:0]  cur_code;
	slice_fmt_e  dec_fmt;
	logic        dec_custom;
	logic [1:0]  dec_sel;
	slice_fmt_e  nxt_fmt;
	logic        nxt_std;
	logic [7:0]  sel_setup;

	// Control bit gives the standard unless a custom setup names its own
	assign std625   = std_ctrl[STD625_BIT];
	assign cur_line = line_mode[line_sel];
	// odd field upper nibble, even field lower
	assign cur_code = field_odd ? cur_line[ODD_LSB +: CODE_W] : cur_line[EVEN_LSB +: CODE_W];

	slice_mode_decode u_decode (
		.code       (cur_code),
		.std625     (std625),
		.fmt        (dec_fmt),
		.is_custom  (dec_custom),
		.custom_sel (dec_sel)
	);

	always_comb begin
		// Select code 3 never comes from the decoder, so it falls to setup one
		sel_setup = cust_setup[0];
		if (dec_sel == 2'h1) begin
			sel_setup = cust_setup[1];
		end else if (dec_sel == 2'h2) begin
			sel_setup = cust_setup[2];
		end
		nxt_fmt = dec_fmt;
		nxt_std = std625;
		if (dec_custom) begin
			nxt_std = sel_setup[CUST_STD_BIT];
			// unknown setup format gives none
			// Values past the last format would otherwise alias the enum
			if (sel_setup[CUST_FMT_LSB +: 4] <= 4'(FMT_PROP_2X)) begin
				nxt_fmt = slice_fmt_e'(sel_setup[CUST_FMT_LSB +: 4]);
			end else begin
				nxt_fmt = FMT_NONE;
			end
		end
		// Between lines the slicer stays idle, whatever is programmed
		if (!line_active) begin
			nxt_fmt = FMT_NONE;
		end
	end

	// ============================================================
	// Registered slicer outputs
	slice_fmt_e fmt_ff;
	logic       enable_ff;
	logic       custom_ff;
	logic [1:0] custom_sel_ff;
	logic       std_out_ff;

	// Registered so the slicer sees no decode glitches; costs one edge of lag
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fmt_ff        <= FMT_NONE;
			enable_ff     <= 1'b0;
			custom_ff     <= 1'b0;
			custom_sel_ff <= 2'h0;
			std_out_ff    <= 1'b0;
		end else begin
			fmt_ff        <= nxt_fmt;
			enable_ff     <= (nxt_fmt != FMT_NONE);
			custom_ff     <= dec_custom && line_active;
			custom_sel_ff <= dec_sel;
			std_out_ff    <= nxt_std;
		end
	end

	assign slice_format     = fmt_ff;
	assign slice_enable     = enable_ff;
	assign slice_custom     = custom_ff;
	assign slice_custom_sel = custom_sel_ff;
	assign slice_std625     = std_out_ff;

	// ============================================================
	// Read channel
	logic              rvalid_ff;
	logic [DATA_W-1:0] rdata_ff;
	logic [1:0]        rresp_ff;
	logic [IDX_W-1:0]  rd_idx;
	logic [7:0]        rd_byte;
	logic              rd_hit;

	// Single read slot; arready reopens as soon as rvalid falls
	assign s_axi_arready = !rvalid_ff;
	assign rd_idx        = s_axi_araddr[ADDR_W-1:2];

	always_comb begin
		// Read decode mirrors the write decode, status added
		rd_byte = 8'h00;
		rd_hit  = 1'b0;
		for (int i = 0; i < LINES; i++) begin
			if (rd_idx == LINE1_IDX + IDX_W'(i)) begin
				rd_byte = line_mode[i];
				rd_hit  = 1'b1;
			end
		end
		for (int k = 0; k < CUSTOM_COUNT; k++) begin
			if (rd_idx == CUSTOM1_IDX + IDX_W'(k)) begin
				rd_byte = cust_setup[k];
				rd_hit  = 1'b1;
			end
		end
		if (rd_idx == STD_CTRL_IDX) begin
			rd_byte = std_ctrl;
			rd_hit  = 1'b1;
		end
		// Live view of what the slicer is told now
		if (rd_idx == STATUS_IDX) begin
			rd_byte = {enable_ff, custom_ff, custom_sel_ff, 4'(fmt_ff)};
			rd_hit  = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= '0;
			rresp_ff  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= {24'h000000, rd_byte};
			// Unmapped words read as zero and flag SLVERR
			rresp_ff  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata  = rdata_ff;
	assign s_axi_rresp  = rresp_ff;

endmodule // vbi_line_slice_mode_regs

// ### sim/vbi_slice_regs_sva.sv
// Purpose: Port-level assertions for the blanking-line slice mode registers.
// Assumes: Single clock domain, synchronous active-low reset.
// Notes:   Bound to the design top from the testbench file.
`timescale 1ns/1ps
module vbi_slice_regs_sva
	import vbi_slice_pkg::*;
#(
	parameter int LINES = 8
) (
	input wire logic                             aclk,
	input wire logic                             aresetn,
	input wire logic                             s_axi_awvalid,
	input wire logic                             s_axi_awready,
	input wire logic                             s_axi_wvalid,
	input wire logic                             s_axi_wready,
	input wire logic                             s_axi_bvalid,
	input wire logic                             s_axi_arvalid,
	input wire logic                             s_axi_arready,
	input wire logic                             s_axi_rvalid,
	input wire logic                             s_axi_rready,
	input wire logic [vbi_slice_pkg::DATA_W-1:0] s_axi_rdata,
	input wire logic                             line_active,
	input vbi_slice_pkg::slice_fmt_e             slice_format,
	input wire logic                             slice_enable,
	input wire logic                             slice_custom
);
	// ============================================================
	// Clocking
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ============================================================
	// Slicer outputs
	chk_enable_format: assert property (slice_enable == (slice_format != FMT_NONE))
		else $error("slice enable disagrees with format");
	chk_idle_no_slice: assert property (!line_active |=> (slice_format == FMT_NONE) && !slice_custom)
		else $error("slicing outside an active line");
	chk_custom_active: assert property (slice_custom |-> $past(line_active))
		else $error("custom flag without active line");
	chk_reset_clear: assert property ($rose(aresetn) |-> (slice_format == FMT_NONE) && !slice_enable)
		else $error("slice output not clear after reset");

	// ============================================================
	// Register bus
	chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid)
		else $error("write response late");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
		else $error("read answer late or too wide");
	chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	chk_busy_refuse: assert property ((s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		and (s_axi_rvalid |-> !s_axi_arready))
		else $error("request accepted while answer pending");
endmodule // vbi_slice_regs_sva

// ### sim/testbench.sv
// Purpose: Self-checking bench for the blanking-line slice mode registers.
// Assumes: Bench drives the bus and slicer timing directly.
// Notes:   Random values from a fixed seed mixed with corner cases.
`timescale 1ns/1ps
module testbench;
	import vbi_slice_pkg::*;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, field_odd, line_active;
	logic        slice_enable, slice_custom, slice_std625;
	logic [15:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [2:0]  line_sel;
	logic [1:0]  bresp, rresp, slice_custom_sel;
	slice_fmt_e  slice_format;
	int          fail_count, check_count;
	logic [7:0]  line_m [8];
	logic [7:0]  cust_m [3];
	logic        std_m;
	logic [7:0]  stat_m;

	vbi_line_slice_mode_regs #(.LINES(8)) uut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .line_sel(line_sel),
		.field_odd(field_odd), .line_active(line_active), .slice_format(slice_format),
		.slice_enable(slice_enable), .slice_custom(slice_custom), .slice_custom_sel(slice_custom_sel),
		.slice_std625(slice_std625));

	// ============================================================
	// Checking and verdict
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic results();
		if (fail_count == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// ============================================================
	// Bus tasks; ready sampled mid-cycle since it is stable between edges
	task automatic wr(input logic [13:0] idx, input logic [7:0] d, input logic [3:0] strb, input logic [1:0] er);
		int n;
		logic a, w, got;
		logic [1:0] r;
		awaddr <= {idx, 2'h0};
		wdata <= {24'h0, d};
		wstrb <= strb;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		got = 1'b0;
		for (n = 0; n < 50 && !got; n++) begin
			@(negedge aclk);
			a = awvalid && awready;
			w = wvalid && wready;
			got = bvalid;
			r = bresp;
			@(posedge aclk);
			if (a) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		@(posedge aclk);
		chk("bvalid", 1, got);
		chk("bresp", er, r);
	endtask

	task automatic rd(input logic [13:0] idx, input logic [7:0] ed, input logic [1:0] er);
		int n;
		logic a, got;
		logic [31:0] d;
		logic [1:0] r;
		araddr <= {idx, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		got = 1'b0;
		for (n = 0; n < 50 && !got; n++) begin
			@(negedge aclk);
			a = arvalid && arready;
			got = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (a) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		@(posedge aclk);
		chk("rvalid", 1, got);
		chk("rdata", {24'h0, ed}, d);
		chk("rresp", er, r);
	endtask

	// ============================================================
	// Expected slicer result from the mode code tables
	function automatic void expect_for(input logic [3:0] c, input logic act, output logic [3:0] f,
		output logic cu, output logic [1:0] sel, output logic s);
		sel = 2'(c - 4'h9);
		cu = 1'b0;
		s = std_m;
		f = FMT_NONE;
		if (c >= 4'h9 && c <= 4'hB) begin
			cu = act;
			s = cust_m[sel][4];
			f = (cust_m[sel][3:0] > 4'hA) ? 4'h0 : cust_m[sel][3:0];
		end else if (!std_m) begin
			case (c)
				4'h1, 4'h3: f = FMT_TT_D;
				4'h2: f = FMT_TT_C;
				4'h4: f = FMT_WSS;
				4'h5: f = FMT_VITC;
				4'h6: f = FMT_CC;
				4'h7: f = FMT_PROP_1X;
				4'h8: f = FMT_PROP_2X;
				default: f = FMT_NONE;
			endcase
		end else begin
			case (c)
				4'h1: f = FMT_TT_B;
				4'h2: f = FMT_TT_A;
				4'h4: f = FMT_WSS;
				4'h5: f = FMT_VITC;
				4'h6: f = FMT_CC;
				4'h7: f = FMT_VPS;
				default: f = FMT_NONE;
			endcase
		end
		if (!act) f = FMT_NONE;
	endfunction

	// Called at a rising edge; result is registered one edge later
	task automatic slc(input int ln, input logic odd, input logic act);
		logic [3:0] c, f;
		logic cu, s;
		logic [1:0] sel;
		c = odd ? line_m[ln][7:4] : line_m[ln][3:0];
		expect_for(c, act, f, cu, sel, s);
		stat_m = {f != 4'h0, cu, (c >= 4'h9 && c <= 4'hB) ? sel : 2'h0, f};
		line_sel <= 3'(ln);
		field_odd <= odd;
		line_active <= act;
		@(posedge aclk);
		#1;
		chk("slice_format", f, slice_format);
		chk("slice_enable", f != 4'h0, slice_enable);
		chk("slice_custom", cu, slice_custom);
		chk("slice_std625", s, slice_std625);
		if (c >= 4'h9 && c <= 4'hB) chk("slice_custom_sel", sel, slice_custom_sel);
		@(posedge aclk);
	endtask

	// ============================================================
	// Clock, watchdog and main sequence
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	initial begin
		#100000;
		fail_count++;
		results();
	end

	initial begin
		int ln, k;
		logic [7:0] v;
		void'($urandom(32'h3BBF));
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{field_odd, line_active, line_sel, awaddr, araddr, wdata, wstrb} = '0;
		foreach (line_m[i]) line_m[i] = 8'h00;
		cust_m = '{8'h07, 8'h15, 8'h03};
		std_m = 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 8; i++) rd(LINE1_IDX + 14'(i), 8'h00, RESP_OKAY);
		for (int i = 0; i < 3; i++) rd(CUSTOM1_IDX + 14'(i), cust_m[i], RESP_OKAY);
		for (int i = 0; i < 8; i++) slc(i, i[0], 1'b1);
		// Every code in both standards, odd field carries the code under test
		for (int s = 0; s < 2; s++) begin
			wr(STD_CTRL_IDX, 8'(s), 4'h1, RESP_OKAY);
			std_m = s[0];
			for (int c = 0; c < 16; c++) begin
				ln = $urandom_range(0, 7);
				v = {4'(c), 4'($urandom)};
				wr(LINE1_IDX + 14'(ln), v, 4'h1, RESP_OKAY);
				line_m[ln] = v;
				slc(ln, 1'b1, 1'b1);
				slc(ln, 1'b0, 1'b1);
			end
		end
		repeat (6) begin
			k = $urandom_range(0, 2);
			v = 8'($urandom_range(0, 31));
			wr(CUSTOM1_IDX + 14'(k), v, 4'h1, RESP_OKAY);
			cust_m[k] = v;
			ln = $urandom_range(0, 7);
			v = {4'(9 + k), 4'($urandom)};
			wr(LINE1_IDX + 14'(ln), v, 4'h1, RESP_OKAY);
			line_m[ln] = v;
			slc(ln, 1'b1, 1'b1);
			slc(ln, 1'b0, 1'b1);
		end
		for (int i = 0; i < 8; i++) begin
			v = 8'($urandom);
			wr(LINE1_IDX + 14'(i), v, 4'h1, RESP_OKAY);
			line_m[i] = v;
		end
		for (int i = 0; i < 8; i++) begin
			rd(LINE1_IDX + 14'(i), line_m[i], RESP_OKAY);
			slc(i, 1'($urandom), 1'($urandom));
		end
		// Status is read-only and shows the last slicer result
		wr(STATUS_IDX, 8'hFF, 4'h1, RESP_OKAY);
		rd(STATUS_IDX, stat_m, RESP_OKAY);
		// Strobe clear and unmapped space must leave registers untouched
		wr(LINE5_IDX, ~line_m[4], 4'h0, RESP_OKAY);
		rd(LINE5_IDX, line_m[4], RESP_OKAY);
		wr(14'h0400, 8'h5A, 4'h1, RESP_SLVERR);
		rd(14'h0400, 8'h00, RESP_SLVERR);
		results();
	end
endmodule // testbench

bind vbi_line_slice_mode_regs vbi_slice_regs_sva #(.LINES(LINES)) u_sva (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .line_active(line_active),
	.slice_format(slice_format), .slice_enable(slice_enable), .slice_custom(slice_custom));
